/* pkg/rac_pkg.sv */
// constants and types shared by the ramp converter control logic
package rac_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_CTRL      = 14'h0610;
  localparam logic [13:0] IDX_DAC_MAN   = 14'h0611;
  localparam logic [13:0] IDX_CAL       = 14'h0612;
  localparam logic [13:0] IDX_RES_FIRST = 14'h0613;
  localparam logic [13:0] IDX_RES_LAST  = 14'h0627;
  localparam logic [13:0] IDX_CMD       = 14'h0628;
  localparam logic [13:0] IDX_FRESH     = 14'h0629;

  localparam int          NUM_INPUTS    = 21;
  localparam int          RES_W         = 10;

  // control register fields
  localparam int          F_MODE_LO     = 0;
  localparam int          F_SEL_LO      = 2;
  localparam int          F_BIAS_LO     = 6;
  localparam int          F_POL         = 8;
  localparam int          F_RATE_LO     = 9;
  localparam int          F_TRIM        = 11;
  localparam int          F_COMP        = 15;
  localparam logic [15:0] CTRL_WR_MASK  = 16'h7fff;
  localparam logic [15:0] CTRL_RESET    = 16'h0280;

  // write this value to the command register to raise a measure pulse
  localparam logic [15:0] CMD_MEASURE   = 16'hff20;

  localparam logic [RES_W-1:0] RAMP_TOP = 10'h3ff;

  // step times per ramp rate code, and the clock
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          STEP_NS_0     = 500;
  localparam int          STEP_NS_1     = 1000;
  localparam int          STEP_NS_2     = 2000;
  localparam int          STEP_NS_3     = 4000;
  localparam int          CNT_W         = 8;

  // least time rounds up to whole cycles
  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
    if (c < 1) c = 1;
    return CNT_W'(c);
  endfunction

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_CALIB  = 2'b01,
    MODE_AUTO   = 2'b10,
    MODE_SUPER  = 2'b11
  } rac_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RAMP  = 2'b01,
    ST_STORE = 2'b10
  } rac_state_t;

endpackage

/* rtl/rac_step_timer.sv */
// ramp step timer: one tick per ramp step at the selected rate
`timescale 1ns/1ns
module rac_step_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_run,
  input  wire logic [1:0]  i_rate,
  output logic             o_tick
);
  import rac_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;

  function automatic logic [CNT_W-1:0] rate_cycles(input logic [1:0] r);
    unique case (r)
      2'h0: return ns_to_cyc(STEP_NS_0);
      2'h1: return ns_to_cyc(STEP_NS_1);
      2'h2: return ns_to_cyc(STEP_NS_2);
      2'h3: return ns_to_cyc(STEP_NS_3);
    endcase
  endfunction

  always_comb begin
    limit = rate_cycles(i_rate);
  end

  // counter restarts whenever the ramp is not running
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else if (cnt >= limit - 8'h01) begin
      cnt    <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 8'h01;
      o_tick <= 1'b0;
    end
  end

endmodule // rac_step_timer

/* rtl/rac_top.sv */
// ramp converter measurement control with apb register access
`timescale 1ns/1ns
module rac_top (
  input  wire logic                      I_CLK,
  input  wire logic                      I_RST,
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [15:0]               I_PADDR,
  input  wire logic [31:0]               I_PWDATA,
  output logic                           O_PREADY,
  output logic      [31:0]               O_PRDATA,
  output logic                           O_PSLVERR,
  input  wire logic                      I_COMP,
  output logic      [rac_pkg::RES_W-1:0] O_RAMP_DAC,
  output logic      [3:0]                O_INPUT_SEL,
  output logic      [4:0]                O_AUTO_CH,
  output logic                           O_AUTO_ACTIVE,
  output logic      [1:0]                O_COMP_BIAS,
  output logic                           O_POLARITY,
  output logic                           O_HALF_TRIM,
  output logic                           O_BUSY
);
  import rac_pkg::*;

  logic [15:0]            ctrl;
  logic [15:0]            dac_man;
  logic [RES_W-1:0]       cal;
  logic [RES_W-1:0]       res [NUM_INPUTS];
  logic [NUM_INPUTS-1:0]  fresh;
  logic                   comp_meta;
  logic                   comp_sync;
  rac_state_t             state;
  rac_mode_t              run_mode;
  logic [RES_W-1:0]       ramp;
  logic [RES_W-1:0]       hit_val;
  logic [4:0]             chan;
  logic                   step_tick;
  logic                   measure;

  logic                   wr_en;
  logic                   rd_en;
  logic [13:0]            idx;
  rac_mode_t              mode;
  logic                   hit;
  logic                   store_now;
  logic [NUM_INPUTS-1:0]  store_vec;
  logic [NUM_INPUTS-1:0]  read_clr;
  logic [31:0]            next_rdata;
  logic                   next_err;

  // word index of the bus address
  function automatic logic [13:0] word_idx(input logic [15:0] a);
    return a[15:2];
  endfunction

  function automatic logic is_result(input logic [13:0] i);
    return (i >= IDX_RES_FIRST) && (i <= IDX_RES_LAST);
  endfunction

  function automatic logic [4:0] result_slot(input logic [13:0] i);
    logic [13:0] d;
    d = i - IDX_RES_FIRST;
    return d[4:0];
  endfunction

  function automatic logic is_mapped(input logic [13:0] i);
    return (i == IDX_CTRL) || (i == IDX_DAC_MAN) || (i == IDX_CAL) ||
           is_result(i) || (i == IDX_CMD) || (i == IDX_FRESH);
  endfunction

  always_comb begin
    idx   = word_idx(I_PADDR);
    wr_en = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    rd_en = I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE;
    mode  = rac_mode_t'(ctrl[F_MODE_LO +: 2]);
    hit   = comp_sync ^ ctrl[F_POL];
  end

  // comparator comes from the analog side, so it is synchronised
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= I_COMP;
      comp_sync <= comp_meta;
    end
  end

  // apb slave: one wait-free access phase, pready from a flop
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PREADY <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL && !I_PENABLE;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = !is_mapped(idx);
    if (idx == IDX_CTRL) begin
      next_rdata[15:0] = {comp_sync, ctrl[14:0]};
    end else if (idx == IDX_DAC_MAN) begin
      next_rdata[15:0] = dac_man;
    end else if (idx == IDX_CAL) begin
      next_rdata[RES_W-1:0] = cal;
    end else if (is_result(idx)) begin
      next_rdata[RES_W-1:0] = res[result_slot(idx)];
    end else if (idx == IDX_CMD) begin
      next_rdata[0] = O_BUSY;
    end else if (idx == IDX_FRESH) begin
      next_rdata[NUM_INPUTS-1:0] = fresh;
    end
  end

  // read data and error are presented in the access phase
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else if (I_PSEL && !I_PENABLE) begin
      O_PRDATA  <= I_PWRITE ? 32'h0000_0000 : next_rdata;
      O_PSLVERR <= next_err;
    end else begin
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
  end

  // control register, comparator bit 15 is read-only
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl <= CTRL_RESET;
    end else if (wr_en && idx == IDX_CTRL) begin
      ctrl <= I_PWDATA[15:0] & CTRL_WR_MASK;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      dac_man <= 16'h0000;
    end else if (wr_en && idx == IDX_DAC_MAN) begin
      dac_man <= I_PWDATA[15:0];
    end
  end

  // measure pulse from the command register write
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      measure <= 1'b0;
    end else begin
      measure <= wr_en && idx == IDX_CMD &&
                 I_PWDATA[15:0] == CMD_MEASURE;
    end
  end

  rac_step_timer rac_step_timer_inst (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_run  (state == ST_RAMP),
    .i_rate (ctrl[F_RATE_LO +: 2]),
    .o_tick (step_tick)
  );

  // conversion sequencer
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state    <= ST_IDLE;
      run_mode <= MODE_MANUAL;
      ramp     <= '0;
      hit_val  <= '0;
      chan     <= 5'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // super-manual never starts a ramp; busy drops pulses
          if (measure && mode != MODE_SUPER) begin
            state    <= ST_RAMP;
            run_mode <= mode;
            ramp     <= '0;
            chan     <= 5'h00;
          end
        end
        ST_RAMP: begin
          if (step_tick) begin
            if (hit) begin
              hit_val <= ramp;
              state   <= ST_STORE;
            end else if (ramp == RAMP_TOP) begin
              hit_val <= RAMP_TOP;
              state   <= ST_STORE;
            end else begin
              ramp <= ramp + 10'h001;
            end
          end
        end
        ST_STORE: begin
          ramp <= '0;
          if (run_mode == MODE_AUTO &&
              chan != 5'(NUM_INPUTS - 1)) begin
            chan  <= chan + 5'h01;
            state <= ST_RAMP;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    store_now = (state == ST_STORE);
    store_vec = '0;
    read_clr  = '0;
    if (store_now && run_mode == MODE_AUTO) begin
      store_vec[chan] = 1'b1;
    end else if (store_now && run_mode == MODE_MANUAL) begin
      store_vec[0] = 1'b1;
    end
    if (rd_en && is_result(idx)) begin
      read_clr[result_slot(idx)] = 1'b1;
    end
  end

  // results change only on completion
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        res[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (store_vec[i]) begin
          res[i] <= hit_val;
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cal <= '0;
    end else if (store_now && run_mode == MODE_CALIB) begin
      cal <= hit_val;
    end
  end

  // fresh flags: set on store, cleared by a read; set wins
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      fresh <= '0;
    end else begin
      fresh <= (fresh & ~read_clr) | store_vec;
    end
  end

  // analog-facing outputs, all from flops
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RAMP_DAC    <= '0;
      O_INPUT_SEL   <= 4'h0;
      O_AUTO_CH     <= 5'h00;
      O_AUTO_ACTIVE <= 1'b0;
      O_COMP_BIAS   <= 2'h0;
      O_POLARITY    <= 1'b0;
      O_HALF_TRIM   <= 1'b0;
      O_BUSY        <= 1'b0;
    end else begin
      if (mode == MODE_SUPER && state == ST_IDLE) begin
        O_RAMP_DAC <= dac_man[RES_W-1:0];
      end else begin
        O_RAMP_DAC <= ramp;
      end
      O_INPUT_SEL   <= ctrl[F_SEL_LO +: 4];
      O_AUTO_ACTIVE <= (state != ST_IDLE) &&
                       (run_mode == MODE_AUTO);
      O_AUTO_CH     <= chan;
      O_COMP_BIAS   <= ctrl[F_BIAS_LO +: 2];
      O_POLARITY    <= ctrl[F_POL];
      O_HALF_TRIM   <= ctrl[F_TRIM];
      // a refused pulse in step mode is not pending work
      O_BUSY        <= (state != ST_IDLE) ||
                       (measure && mode != MODE_SUPER);
    end
  end

endmodule // rac_top

/* verif/rac_top_assertions.sv */
// concurrent checks on the ramp converter control ports
`timescale 1ns/1ns
module rac_top_checker
  import rac_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [15:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic        O_PREADY,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PSLVERR,
  input wire logic [9:0]  O_RAMP_DAC,
  input wire logic [3:0]  O_INPUT_SEL,
  input wire logic [4:0]  O_AUTO_CH,
  input wire logic        O_AUTO_ACTIVE,
  input wire logic [1:0]  O_COMP_BIAS,
  input wire logic        O_POLARITY,
  input wire logic        O_HALF_TRIM,
  input wire logic        O_BUSY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic       wr;
  logic [1:0] mode;
  assign wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  // shadow of the mode field, needed to know whether a measure may start
  always_ff @(posedge I_CLK) begin
    if (I_RST) mode <= 2'h0;
    else if (wr && I_PADDR[15:2] == IDX_CTRL) mode <= I_PWDATA[1:0];
  end
  sequence s_ctrl;
    wr && I_PADDR[15:2] == IDX_CTRL;
  endsequence
  sequence s_cmd;
    wr && I_PADDR[15:2] == IDX_CMD && I_PWDATA[15:0] == CMD_MEASURE;
  endsequence
  a_ready_setup:
    assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  a_ready_access:
    assert property (O_PREADY |-> I_PSEL && I_PENABLE)
    else $error("ready outside access");
  a_err_ready:
    assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  a_rdata_idle:
    assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data not cleared");
  a_measure_start:
    assert property (s_cmd ##0 (!O_BUSY && mode != 2'h3) |-> ##[1:2] O_BUSY)
    else $error("measure did not start");
  a_super_idle:
    assert property (s_cmd ##0 (!O_BUSY && mode == 2'h3) |=> !O_BUSY [*3])
    else $error("conversion started in step mode");
  a_sel_follow:
    assert property (s_ctrl |-> ##2 O_INPUT_SEL == $past(I_PWDATA[5:2], 2))
    else $error("input select not applied");
  a_field_follow:
    assert property (s_ctrl |-> ##2 {O_HALF_TRIM, O_POLARITY, O_COMP_BIAS}
      == {$past(I_PWDATA[11], 2), $past(I_PWDATA[8:6], 2)})
    else $error("control fields not applied");
  a_auto_order:
    assert property ($past(O_AUTO_ACTIVE) && O_AUTO_ACTIVE
      && O_AUTO_CH != $past(O_AUTO_CH) |-> O_AUTO_CH == $past(O_AUTO_CH) + 5'h1)
    else $error("channel order broken");
  a_ramp_step:
    assert property (O_BUSY && O_RAMP_DAC == $past(O_RAMP_DAC) + 10'h1
      |=> (O_RAMP_DAC != $past(O_RAMP_DAC) + 10'h1) [*4])
    else $error("ramp step too short");
endmodule // rac_top_checker

bind rac_top rac_top_checker rac_top_checker_inst (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR),
  .O_RAMP_DAC(O_RAMP_DAC), .O_INPUT_SEL(O_INPUT_SEL), .O_AUTO_CH(O_AUTO_CH),
  .O_AUTO_ACTIVE(O_AUTO_ACTIVE), .O_COMP_BIAS(O_COMP_BIAS),
  .O_POLARITY(O_POLARITY), .O_HALF_TRIM(O_HALF_TRIM), .O_BUSY(O_BUSY));

/* verif/rac_comp_model.sv */
// comparator model: trips once the ramp reaches a per-input level
`timescale 1ns/1ns
module rac_comp_model #(
  parameter logic [9:0] BASE = 10'h010,
  parameter logic [9:0] STEP = 10'h003
) (
  input  wire logic [9:0] i_ramp,
  input  wire logic [3:0] i_sel,
  input  wire logic [4:0] i_ch,
  input  wire logic       i_auto,
  output logic            o_comp
);
  logic [4:0] ch;
  assign ch = i_auto ? i_ch : {1'b0, i_sel};
  // each input is a steady level; no fixed answer
  assign o_comp = i_ramp >= BASE + STEP * 10'(ch);
endmodule // rac_comp_model

/* verif/tb_ramp_adc_measurement_control.sv */
// self-checking bench for the ramp converter control block
`timescale 1ns/1ns
module tb_ramp_adc_measurement_control;
  import rac_pkg::*;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, comp, aact;
  logic        pol, trim, busy;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  ramp;
  logic [3:0]  isel;
  logic [4:0]  ach;
  logic [1:0]  bias;
  int          fail_count = 0;
  int          tests_run = 0;

  rac_top rac_top_inst (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_COMP(comp),
    .O_RAMP_DAC(ramp), .O_INPUT_SEL(isel), .O_AUTO_CH(ach),
    .O_AUTO_ACTIVE(aact), .O_COMP_BIAS(bias), .O_POLARITY(pol),
    .O_HALF_TRIM(trim), .O_BUSY(busy));
  rac_comp_model rac_comp_model_inst (.i_ramp(ramp), .i_sel(isel),
    .i_ch(ach), .i_auto(aact), .o_comp(comp));

  function automatic logic [9:0] thr(input int c);
    return 10'h010 + 10'(3 * c);
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] ix,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [13:0] ix, input logic [31:0] d);
    logic [31:0] q;
    logic        er;
    apb(1'b1, ix, d, q, er);
  endtask
  task automatic rdc(input string nm, input logic [13:0] ix,
                     input logic [31:0] e);
    logic [31:0] q;
    logic        er;
    apb(1'b0, ix, 32'h0, q, er);
    chk(nm, q, e);
  endtask
  task automatic meas();
    wr(IDX_CMD, {16'h0, CMD_MEASURE});
  endtask
  task automatic idle(output int n);
    n = 0;
    // busy rises two edges after the command write
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk("busy", 32'(busy), 32'h0);
  endtask
  task automatic tick(input logic [9:0] v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ramp !== v && n < 1000);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rdc("ctrl_rst", IDX_CTRL, {16'h0, CTRL_RESET});
    chk("bias_rst", 32'(bias), 32'h00000002);
    wr(IDX_CTRL, 32'h0000ffff);
    rdc("ctrl_ro", IDX_CTRL, 32'h00007fff);
    chk("fields", 32'({isel, bias, pol, trim}), 32'h000000ff);
    apb(1'b0, 14'h0700, 32'h0, q, e);
    chk("unmapped", 32'(e), 32'h1);
  endtask
  task automatic t_calib();
    int n;
    wr(IDX_CTRL, 32'h0000009d); // calibration on input 7
    meas();
    idle(n);
    rdc("cal", IDX_CAL, 32'(thr(7)));
    wr(IDX_CTRL, 32'h00000181); // inverted polarity on input 0
    meas();
    idle(n);
    rdc("cal_pol", IDX_CAL, 32'h0);
    wr(IDX_CTRL, 32'h0000009d); // final calibration settings
    meas();
    idle(n);
    rdc("cal_ref", IDX_CAL, 32'(thr(7)));
    rdc("res_keep", IDX_RES_FIRST, 32'h0);
  endtask
  task automatic t_rate();
    int n;
    for (int r = 0; r < 4; r++) begin
      wr(IDX_CTRL, 32'(32'h80 | (r << 9)));
      meas();
      tick(10'h1, n);
      tick(10'h2, n);
      chk("step", 32'(n), 32'(5 << r));
      idle(n);
    end
    rdc("res0", IDX_RES_FIRST, 32'(thr(0)));
  endtask
  task automatic t_man();
    int n;
    wr(IDX_CTRL, 32'h00000090); // manual mode on input 4, bias 2
    meas();
    meas(); // second request lands while busy
    rdc("busy_reg", IDX_CMD, 32'h1);
    rdc("hold", IDX_RES_FIRST, 32'(thr(0)));
    rdc("cal_keep", IDX_CAL, 32'(thr(7)));
    idle(n);
    chk("single", 32'(n < 250), 32'h1);
    rdc("fresh", IDX_FRESH, 32'h1);
    rdc("manual", IDX_RES_FIRST, 32'(thr(4)));
  endtask
  task automatic t_auto();
    int          n;
    logic [31:0] q;
    logic [31:0] c;
    logic        e;
    wr(IDX_CTRL, 32'h000000be); // auto scan of all inputs, bias and polarity as in calibration
    meas();
    idle(n);
    apb(1'b0, IDX_CAL, 32'h0, c, e);
    for (int i = 0; i < NUM_INPUTS; i++) begin
      apb(1'b0, IDX_RES_FIRST + 14'(i), 32'h0, q, e);
      chk("auto", q, 32'(thr(i)));
      chk("corrected", q - c, 32'(thr(i)) - 32'(thr(7)));
    end
  endtask
  task automatic t_super();
    wr(IDX_CTRL, 32'h00000083);
    wr(IDX_DAC_MAN, 32'h00000155);
    repeat (4) @(posedge clk);
    chk("ramp", 32'(ramp), 32'h00000155);
    rdc("comp_hi", IDX_CTRL, 32'h00008083);
    wr(IDX_DAC_MAN, 32'h00000005);
    repeat (4) @(posedge clk);
    rdc("comp_lo", IDX_CTRL, 32'h00000083);
    meas();
    repeat (3) @(posedge clk);
    chk("no_ramp", 32'(busy), 32'h0);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_calib();
    t_rate();
    t_man();
    t_auto();
    t_super();
    complete_run();
  end
endmodule // tb_ramp_adc_measurement_control
